// *** hw/two_port_parallel_io_cfg.svh ***
// Register word indices, field widths and reset values of the two-port parallel I/O block.
// Assumes inclusion by bare name from the design files.
`ifndef TWO_PORT_PARALLEL_IO_CFG_SVH
`define TWO_PORT_PARALLEL_IO_CFG_SVH
`define FIRST_PORT_DATA_IDX       12'h000
`define SECOND_PORT_DATA_IDX      12'h001
`define FIRST_PORT_DIRECTION_IDX  12'h004
`define SECOND_PORT_DIRECTION_IDX 12'h005
`define FIRST_PORT_PULLUP_IDX     12'h00D
`define TIMER_SELECT_IDX          12'h010
`define KEYPAD_ENABLE_IDX         12'h011
`define FIRST_PORT_WIDTH          5
`define SECOND_PORT_WIDTH         8
`define TIMER_CHANNELS            2
`define TIMER_ZERO_PIN            2
`define TIMER_ONE_PIN             3
`define REG_RESET_5               5'h00
`define REG_RESET_8               8'h00
`define REG_RESET_4               4'h0
`define READ_ZERO_32              32'h00000000
`define SYNC_ZERO_5               5'h00
`define SYNC_ZERO_8               8'h00
`endif

// *** hw/two_port_parallel_io_pkg.sv ***
// Types shared by the two-port parallel I/O block.
// Assumes the cfg header is compiled alongside.
package two_port_parallel_io_pkg;
    typedef logic [4:0] first_port_bits_t;
    typedef logic [7:0] second_port_bits_t;
endpackage : two_port_parallel_io_pkg

// *** hw/pin_sync.sv ***
// Three-stage synchroniser with agreement filter for a group of pins.
// Assumes pins change asynchronously to i_clk.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // The first stage feeds only the second; metastability must not reach the filter.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            stage1  <= '0;
            stage2  <= '0;
            stage3  <= '0;
            o_level <= '0;
        end else begin
            stage1 <= i_pins;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    o_level[i] <= stage3[i];
                end
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// *** hw/two_port_parallel_io.sv ***
// Two-port parallel I/O block: a five-pin port and an eight-pin port behind an APB slave.
// Assumes pins are resolved by the board; pullups and shared functions enter as plain ports.
//
// What this block does
// R1 - Five-pin and eight-pin ports, each pin programmable.
// R2 - First port has per-pin readable writable latches.
// R3 - Reset leaves first port latches unchanged.
// R4 - First port direction bits steer each pin.
// R5 - Direction 1 drives pin, 0 makes input.
// R6 - Pullup only when enabled and general input.
// R7 - Keypad enables turn pins into interrupt inputs.
// R8 - Pins 3 and 2 serve timer channels.
// R9 - Data reads: latch for outputs, pin for inputs.
// R10 - Second port direction works like the first.
`include "two_port_parallel_io_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module two_port_parallel_io (
    input  wire logic                                   i_clk,
    input  wire logic                                   i_nrst,
    input  wire logic                                   i_psel,
    input  wire logic                                   i_penable,
    input  wire logic                                   i_pwrite,
    input  wire logic [11:0]                            i_paddr,
    input  wire logic [31:0]                            i_pwdata,
    input  wire logic [3:0]                             i_pstrb,
    output logic      [31:0]                            o_prdata,
    output logic                                        o_pready,
    output logic                                        o_pslverr,
    input  wire two_port_parallel_io_pkg::first_port_bits_t  i_first_port_pins,
    output logic      [`FIRST_PORT_WIDTH-1:0]           o_first_port_pins,
    output logic      [`FIRST_PORT_WIDTH-1:0]           o_first_port_pins_oe,
    output logic      [`FIRST_PORT_WIDTH-1:0]           o_first_port_pullup_on,
    input  wire two_port_parallel_io_pkg::second_port_bits_t i_second_port_pins,
    output logic      [`SECOND_PORT_WIDTH-1:0]          o_second_port_pins,
    output logic      [`SECOND_PORT_WIDTH-1:0]          o_second_port_pins_oe,
    input  wire logic [`TIMER_CHANNELS-1:0]             i_timer_channel_out,
    input  wire logic [`TIMER_CHANNELS-1:0]             i_timer_channel_drive,
    output logic      [`TIMER_CHANNELS-1:0]             o_timer_channel_in,
    output logic      [`FIRST_PORT_WIDTH-1:0]           o_keypad_wakeup_pins
);

    ////////////////////////////////////////////////////////////////////////////////////
    // Registers.

    two_port_parallel_io_pkg::first_port_bits_t  first_port_data;
    two_port_parallel_io_pkg::second_port_bits_t second_port_data;
    two_port_parallel_io_pkg::first_port_bits_t  first_port_direction;
    two_port_parallel_io_pkg::second_port_bits_t second_port_direction;
    two_port_parallel_io_pkg::first_port_bits_t  first_port_pullup_enable;
    logic [3:0]                                  timer_select;
    two_port_parallel_io_pkg::first_port_bits_t  keypad_pin_irq_enables;
    two_port_parallel_io_pkg::first_port_bits_t  first_level;
    two_port_parallel_io_pkg::second_port_bits_t second_level;
    two_port_parallel_io_pkg::first_port_bits_t  first_general;
    logic [`TIMER_CHANNELS-1:0]                  timer_owns;
    logic                                        wr_en;
    logic                                        rd_en;
    logic [31:0]                                 next_prdata;

    assign wr_en     = i_psel && i_penable && i_pwrite && i_pstrb[0];
    assign rd_en     = i_psel && !i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
        hit = (addr == {idx[9:0], 2'b00});
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////////
    // Data latches have no reset so that the latched output value survives a system reset.

    always_ff @(posedge i_clk) begin
        if (wr_en && hit(i_paddr, `FIRST_PORT_DATA_IDX)) begin // [R3]
            first_port_data <= i_pwdata[`FIRST_PORT_WIDTH-1:0]; // [R2]
        end
    end

    always_ff @(posedge i_clk) begin
        if (wr_en && hit(i_paddr, `SECOND_PORT_DATA_IDX)) begin
            second_port_data <= i_pwdata[`SECOND_PORT_WIDTH-1:0];
        end
    end

    // Simulation starts these latches unknown; software must write before enabling drivers.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            first_port_direction <= `REG_RESET_5;
        end else if (wr_en && hit(i_paddr, `FIRST_PORT_DIRECTION_IDX)) begin
            first_port_direction <= i_pwdata[`FIRST_PORT_WIDTH-1:0]; // [R4]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            second_port_direction <= `REG_RESET_8;
        end else if (wr_en && hit(i_paddr, `SECOND_PORT_DIRECTION_IDX)) begin
            second_port_direction <= i_pwdata[`SECOND_PORT_WIDTH-1:0]; // [R10]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            first_port_pullup_enable <= `REG_RESET_5;
        end else if (wr_en && hit(i_paddr, `FIRST_PORT_PULLUP_IDX)) begin
            first_port_pullup_enable <= i_pwdata[`FIRST_PORT_WIDTH-1:0];
        end
    end

    // Bits [1:0] are channel zero's edge/level select, [3:2] channel one's.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            timer_select <= `REG_RESET_4;
        end else if (wr_en && hit(i_paddr, `TIMER_SELECT_IDX)) begin
            timer_select <= i_pwdata[3:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            keypad_pin_irq_enables <= `REG_RESET_5;
        end else if (wr_en && hit(i_paddr, `KEYPAD_ENABLE_IDX)) begin
            keypad_pin_irq_enables <= i_pwdata[`FIRST_PORT_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    pin_sync #(.WIDTH(`FIRST_PORT_WIDTH)) first_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_pins  (i_first_port_pins),
        .o_level (first_level)
    );

    pin_sync #(.WIDTH(`SECOND_PORT_WIDTH)) second_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_pins  (i_second_port_pins),
        .o_level (second_level)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // Pin function selection.

    // Either edge/level select bit set hands the pin to its timer channel.
    function automatic logic channel_claims(input logic [1:0] edge_level);
        channel_claims = |edge_level;
    endfunction : channel_claims

    assign timer_owns[0] = channel_claims(timer_select[1:0]); // [R8]
    assign timer_owns[1] = channel_claims(timer_select[3:2]); // [R8]

    genvar g;
    generate
        for (g = 0; g < `FIRST_PORT_WIDTH; g++) begin : g_first
            if (g == `TIMER_ZERO_PIN || g == `TIMER_ONE_PIN) begin : g_tim
                localparam int CH = (g == `TIMER_ZERO_PIN) ? 0 : 1;
                assign first_general[g] = !timer_owns[CH]; // [R8]
            end else begin : g_gpio
                assign first_general[g] = 1'b1;
            end
        end
    endgenerate

    // Pin outputs come from flops so the board sees no glitches from the select muxes.
    two_port_parallel_io_pkg::first_port_bits_t  next_first_pins;
    two_port_parallel_io_pkg::first_port_bits_t  next_first_oe;
    two_port_parallel_io_pkg::first_port_bits_t  next_first_pull;

    generate
        for (g = 0; g < `FIRST_PORT_WIDTH; g++) begin : g_drive
            if (g == `TIMER_ZERO_PIN || g == `TIMER_ONE_PIN) begin : g_tim
                localparam int CH = (g == `TIMER_ZERO_PIN) ? 0 : 1;
                // The timer sets both value and enable of a pin that it owns.
                assign next_first_pins[g] = timer_owns[CH] ? i_timer_channel_out[CH]
                                                           : first_port_data[g]; // [R8]
                assign next_first_oe[g]   = timer_owns[CH] ? i_timer_channel_drive[CH]
                                                           : first_port_direction[g]; // [R5]
            end else begin : g_gpio
                assign next_first_pins[g] = first_port_data[g]; // [R2]
                assign next_first_oe[g]   = first_port_direction[g]; // [R5]
            end
            // A pull is never left on against a driven or a shared pin.
            assign next_first_pull[g] = first_port_pullup_enable[g] && first_general[g]
                                        && !first_port_direction[g]; // [R6]
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_first_port_pins      <= `REG_RESET_5;
            o_first_port_pins_oe   <= `REG_RESET_5;
            o_first_port_pullup_on <= `REG_RESET_5;
        end else begin
            o_first_port_pins      <= next_first_pins;
            o_first_port_pins_oe   <= next_first_oe;
            o_first_port_pullup_on <= next_first_pull;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_second_port_pins    <= `REG_RESET_8;
            o_second_port_pins_oe <= `REG_RESET_8;
        end else begin
            o_second_port_pins    <= second_port_data;
            o_second_port_pins_oe <= second_port_direction; // [R10] [R1]
        end
    end

    // The timer always sees its pins, so input capture works while it drives them.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_timer_channel_in <= '0;
        end else begin
            o_timer_channel_in[0] <= first_level[`TIMER_ZERO_PIN]; // [R8]
            o_timer_channel_in[1] <= first_level[`TIMER_ONE_PIN]; // [R8]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_keypad_wakeup_pins <= `REG_RESET_5;
        end else begin
            o_keypad_wakeup_pins <= first_level & keypad_pin_irq_enables; // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Address decode for the read mux.

    logic                                        sel_first_data;
    logic                                        sel_second_data;
    logic                                        sel_first_dir;
    logic                                        sel_second_dir;
    logic                                        sel_pullup;
    logic                                        sel_timer;
    logic                                        sel_keypad;
    logic                                        sel_none;
    logic                                        read_setup;
    logic [7:0]                                  first_view;
    logic [7:0]                                  second_view;
    logic [31:0]                                 rd_first_data;
    logic [31:0]                                 rd_second_data;
    logic [31:0]                                 rd_first_dir;
    logic [31:0]                                 rd_second_dir;
    logic [31:0]                                 rd_pullup;
    logic [31:0]                                 rd_timer;
    logic [31:0]                                 rd_keypad;

    assign sel_first_data  = hit(i_paddr, `FIRST_PORT_DATA_IDX);
    assign sel_second_data = hit(i_paddr, `SECOND_PORT_DATA_IDX);
    assign sel_first_dir   = hit(i_paddr, `FIRST_PORT_DIRECTION_IDX);
    assign sel_second_dir  = hit(i_paddr, `SECOND_PORT_DIRECTION_IDX);
    assign sel_pullup      = hit(i_paddr, `FIRST_PORT_PULLUP_IDX);
    assign sel_timer       = hit(i_paddr, `TIMER_SELECT_IDX);
    assign sel_keypad      = hit(i_paddr, `KEYPAD_ENABLE_IDX);
    // Unmapped words read zero and raise no error, so software may probe freely.
    assign sel_none        = !(sel_first_data || sel_second_data || sel_first_dir
                               || sel_second_dir || sel_pullup || sel_timer || sel_keypad);
    assign read_setup      = rd_en && !i_penable;

    ////////////////////////////////////////////////////////////////////////////////////
    // Pin view of the data registers.

    // Outputs read back their latch; inputs read the synchronised pin level.
    function automatic logic [7:0] pin_view(input logic [7:0] latch,
                                            input logic [7:0] dir,
                                            input logic [7:0] level);
        pin_view = (latch & dir) | (level & ~dir);
    endfunction : pin_view

    assign first_view  = pin_view(8'(first_port_data), 8'(first_port_direction),
                                  8'(first_level)); // [R9]
    assign second_view = pin_view(second_port_data, second_port_direction,
                                  second_level); // [R9]

    ////////////////////////////////////////////////////////////////////////////////////
    // Read words, each zero above its register width.

    assign rd_first_data  = 32'(first_view); // [R9]
    assign rd_second_data = 32'(second_view); // [R9]
    assign rd_first_dir   = 32'(first_port_direction);
    assign rd_second_dir  = 32'(second_port_direction);
    assign rd_pullup      = 32'(first_port_pullup_enable);
    assign rd_timer       = 32'(timer_select);
    assign rd_keypad      = 32'(keypad_pin_irq_enables);

    ////////////////////////////////////////////////////////////////////////////////////
    // APB read data, registered at setup so it is stable through the access phase.

    always_comb begin
        next_prdata = `READ_ZERO_32;
        unique case (1'b1)
            sel_first_data: begin
                next_prdata = rd_first_data;
            end
            sel_second_data: begin
                next_prdata = rd_second_data;
            end
            sel_first_dir: begin
                next_prdata = rd_first_dir;
            end
            sel_second_dir: begin
                next_prdata = rd_second_dir;
            end
            sel_pullup: begin
                next_prdata = rd_pullup;
            end
            sel_timer: begin
                next_prdata = rd_timer;
            end
            sel_keypad: begin
                next_prdata = rd_keypad;
            end
            sel_none: begin
                next_prdata = `READ_ZERO_32;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_prdata <= `READ_ZERO_32;
        end else if (read_setup) begin
            o_prdata <= next_prdata;
        end
    end

endmodule : two_port_parallel_io
`default_nettype wire

// *** tb/board_pins.sv ***
// Board model: resolves each pin from the block's drive, a pullup and outside drivers.
// Assumes the outside drivers let go of any pin that the block drives.
`timescale 1ns/10ps
`default_nettype none
module board_pins #(
    parameter int W = 5
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_oe,
    input  wire logic [W-1:0] i_pu,
    input  wire logic [W-1:0] i_ext,
    input  wire logic [W-1:0] i_ext_en,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] flip = '0;
    always @(posedge i_clk) flip <= ~flip;
    // A floating pin wanders each cycle, so a stale level is never mistaken for a reading.
    assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
                   | (~i_oe & ~i_ext_en & (i_pu | flip));
endmodule : board_pins
`default_nettype wire

// *** tb/two_port_parallel_io_properties.sv ***
// Port checker for the two-port parallel I/O block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module two_port_parallel_io_properties (
    input wire logic                                        i_clk,
    input wire logic                                        i_nrst,
    input wire logic                                        i_psel,
    input wire logic                                        i_penable,
    input wire logic                                        i_pwrite,
    input wire logic [11:0]                                 i_paddr,
    input wire logic [31:0]                                 i_pwdata,
    input wire logic [3:0]                                  i_pstrb,
    input wire logic [31:0]                                 o_prdata,
    input wire logic                                        o_pready,
    input wire logic                                        o_pslverr,
    input wire two_port_parallel_io_pkg::first_port_bits_t  i_first_port_pins,
    input wire logic [4:0]                                  o_first_port_pins_oe,
    input wire logic [4:0]                                  o_first_port_pullup_on,
    input wire logic [7:0]                                  o_second_port_pins,
    input wire logic [7:0]                                  o_second_port_pins_oe,
    input wire logic [1:0]                                  o_timer_channel_in,
    input wire logic [4:0]                                  o_keypad_wakeup_pins
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic wr;
    logic rd;
    assign wr = i_psel & i_penable & i_pwrite & i_pstrb[0];
    assign rd = i_psel & i_penable & !i_pwrite;
    a_ready_no_err: assert property (o_pready && !o_pslverr)
        else $error("bus answer not ready or error");
    a_first_dir: assert property (wr && i_paddr == 12'h010 |-> ##2
        o_first_port_pins_oe[4] == $past(i_pwdata[4], 2)
        && o_first_port_pins_oe[1:0] == $past(i_pwdata[1:0], 2)) else $error("port one drive");
    a_second_dir: assert property (wr && i_paddr == 12'h014 |-> ##2
        o_second_port_pins_oe == $past(i_pwdata[7:0], 2)) else $error("port two drive");
    a_pullup_input: assert property ((o_first_port_pullup_on & o_first_port_pins_oe) == 5'h00)
        else $error("pullup on a driven pin");
    a_read_upper: assert property (rd |-> o_prdata[31:8] == 24'h000000
        && (i_paddr != 12'h000 || o_prdata[7:5] == 3'h0)) else $error("upper bits not zero");
    a_read_driven: assert property (rd && i_paddr == 12'h004 |->
        ((o_prdata[7:0] ^ o_second_port_pins) & o_second_port_pins_oe) == 8'h00)
        else $error("driven pin reads wrong");
    a_timer_sync: assert property ($stable(i_first_port_pins)[*7] |->
        o_timer_channel_in == {i_first_port_pins[3], i_first_port_pins[2]})
        else $error("timer pin level wrong");
    a_keypad_masked: assert property ($stable(i_first_port_pins)[*7] |->
        (o_keypad_wakeup_pins & ~i_first_port_pins) == 5'h00) else $error("keypad level wrong");
    cover property (wr && i_paddr == 12'h010);
    cover property (rd && i_paddr == 12'h004);
    cover property ($stable(i_first_port_pins)[*7]);
endmodule : two_port_parallel_io_properties
`default_nettype wire

// *** tb/tb_two_port_parallel_io.sv ***
// Self-checking bench for the two-port parallel I/O block.
// Assumes the design, its package, the board model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_two_port_parallel_io;
    logic        i_clk, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, q;
    logic [3:0]  i_pstrb;
    two_port_parallel_io_pkg::first_port_bits_t  i_first_port_pins;
    two_port_parallel_io_pkg::second_port_bits_t i_second_port_pins;
    logic [4:0]  o_first_port_pins, o_first_port_pins_oe, o_first_port_pullup_on;
    logic [4:0]  o_keypad_wakeup_pins, ext_a, en_a, om, eoe, eout, epu, lva, ka;
    logic [7:0]  o_second_port_pins, o_second_port_pins_oe, ext_b, en_b, lvb, kb;
    logic [1:0]  i_timer_channel_out, i_timer_channel_drive, o_timer_channel_in;
    int          errors, n_compared, dat_a, dat_b, dir_a, dir_b, pue, tsel, kbe, n;
    two_port_parallel_io dut (.*);
    board_pins #(.W(5)) board_a (.i_clk, .i_out(o_first_port_pins), .i_oe(o_first_port_pins_oe),
        .i_pu(o_first_port_pullup_on), .i_ext(ext_a), .i_ext_en(en_a), .o_level(i_first_port_pins));
    board_pins #(.W(8)) board_b (.i_clk, .i_out(o_second_port_pins), .i_oe(o_second_port_pins_oe),
        .i_pu(8'h00), .i_ext(ext_b), .i_ext_en(en_b), .o_level(i_second_port_pins));
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp
    // One idle cycle follows each transfer so no strobe is assigned twice in a step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d; i_penable <= 1'b0;
        @(posedge i_clk);
        i_penable <= 1'b1;
        k = 0;
        do begin @(posedge i_clk); k++; end while (o_pready !== 1'b1 && k < 50);
        if (k >= 50) begin errors++; end_of_test(); end
        q = o_prdata;
        i_psel <= 1'b0; i_penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        cmp(e & m, q & m);
    endtask : rd
    ////////////////////////////////////////////////////////////////
    initial begin i_clk = 1'b0; forever #5 i_clk = ~i_clk; end
    initial begin
        {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {ext_a, en_a, ext_b, en_b, i_timer_channel_out, i_timer_channel_drive} = '0;
        i_pstrb = 4'h1; errors = 0; n_compared = 0;
        void'($urandom(9));
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        rd(12'h010, 32'h0, '1);
        rd(12'h014, 32'h0, '1);
        rd(12'h034, 32'h0, '1);
        wr(12'h008, 32'hFFFFFFFF);
        rd(12'h008, 32'h0, '1);
        for (int i = 0; i < 24; i++) begin
            ext_a <= 5'($urandom); en_a <= 5'($urandom); ext_b <= 8'($urandom); en_b <= 8'($urandom);
            {i_timer_channel_out, i_timer_channel_drive} <= 4'($urandom);
            dat_a = $urandom; dat_b = $urandom; dir_a = $urandom; dir_b = $urandom;
            pue = $urandom; tsel = $urandom; kbe = $urandom;
            wr(12'h000, dat_a); wr(12'h004, dat_b); wr(12'h010, dir_a); wr(12'h014, dir_b);
            wr(12'h034, pue); wr(12'h040, tsel); wr(12'h044, kbe);
            repeat (10) @(posedge i_clk);
            om = {1'b0, tsel[3:2] != 2'b00, tsel[1:0] != 2'b00, 2'b00};
            eoe = (dir_a[4:0] & ~om) | ({1'b0, i_timer_channel_drive, 2'b00} & om);
            eout = (dat_a[4:0] & ~om) | ({1'b0, i_timer_channel_out, 2'b00} & om);
            epu = pue[4:0] & ~dir_a[4:0] & ~om;
            lva = (eoe & eout) | (~eoe & en_a & ext_a) | (~eoe & ~en_a & epu);
            ka = eoe | en_a | epu;
            lvb = (dir_b[7:0] & dat_b[7:0]) | (~dir_b[7:0] & en_b & ext_b);
            kb = dir_b[7:0] | en_b;
            cmp(32'(eoe), 32'(o_first_port_pins_oe));
            cmp(32'(eout & eoe), 32'(o_first_port_pins & eoe));
            cmp(32'(epu), 32'(o_first_port_pullup_on));
            cmp(32'(dir_b[7:0]), 32'(o_second_port_pins_oe));
            cmp(32'(lvb & dir_b[7:0]), 32'(o_second_port_pins & dir_b[7:0]));
            cmp(32'(lva & ka & kbe[4:0]), 32'(o_keypad_wakeup_pins & ka));
            cmp(32'(lva[3:2] & ka[3:2]), 32'(o_timer_channel_in & ka[3:2]));
            rd(12'h000, ((dat_a & dir_a) | (lva & ~dir_a)) & 32'h1F, {27'h7FFFFFF, ka & ~om});
            rd(12'h004, 32'(lvb), {24'hFFFFFF, kb});
            rd(12'h010, dir_a & 32'h1F, '1);
        end
        n = dat_a;
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        wr(12'h010, 32'h1F);
        rd(12'h000, n & 32'h1F, '1);
        end_of_test();
    end
endmodule : tb_two_port_parallel_io
bind two_port_parallel_io two_port_parallel_io_properties chk (.*);
`default_nettype wire
